// >>> tb_usb_host_irq_status_enable.sv
`timescale 1ns/1ps
module tb_usb_host_irq_status_enable;
  typedef struct packed {
    logic [9:0] ev;
    logic [15:0] st;
  } uhi_row_s;
  // Short settle so the reserved status bit rises early in the run
  localparam int SETTLE = 4;
  localparam logic [9:0] SA = uhi_pkg::STATUS_ADDR;
  localparam logic [9:0] EA = uhi_pkg::ENABLE_ADDR;
  logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, host_irq;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [15:0] irq_status;
  uhi_pkg::uhi_evt_s evt;
  int err_count, n_compared;
  // One event source per row, with the status bit it must latch
  uhi_row_s rows [10] = '{
    '{10'h001, 16'h0001},
    '{10'h002, 16'h0002},
    '{10'h004, 16'h0008},
    '{10'h008, 16'h0010},
    '{10'h010, 16'h0020},
    '{10'h020, 16'h0040},
    '{10'h040, 16'h0080},
    '{10'h080, 16'h0100},
    '{10'h100, 16'h0200},
    '{10'h200, 16'h0400}
  };

  uhi_host_irq #(.SETTLE_CYC(SETTLE)) i_uhi_host_irq (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .evt(evt),
    .host_irq(host_irq),
    .irq_status(irq_status)
  );

  // Free-running 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bus cycle: hold everything until waitrequest is sampled low; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [9:0] a, input logic [15:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("wait cycles", 32'd2, n);
  endtask

  task automatic rdchk(input string nm, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, 4'h3, q);
    chk(nm, exp, q);
  endtask

  // Event pulses last exactly one cycle, as the host core gives them
  task automatic pulse(input logic [9:0] v);
    @(posedge clk_sys);
    evt <= v;
    @(posedge clk_sys);
    evt <= '0;
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence: reset checks first, then the table loop, then the awkward cases
  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'h0;
    evt = '0;
    err_count = 0;
    n_compared = 0;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk("reserved bit at release", 32'h0, {16'h0000, irq_status});
    rdchk("enable reset", EA, 32'h0);
    repeat (SETTLE + 2) @(posedge clk_sys);
    chk("reserved bit settled", 32'h4, {16'h0000, irq_status});
    $display("test reset done");
    foreach (rows[i]) begin
      pulse(rows[i].ev);
      repeat (3) @(posedge clk_sys);
      chk("irq masked", 32'h0, {31'h0, host_irq});
      rdchk("status set", SA, {16'h0000, rows[i].st | 16'h0004});
      bus(1'b1, EA, rows[i].st, 4'h3, rd);
      repeat (2) @(posedge clk_sys);
      chk("irq enabled", 32'h1, {31'h0, host_irq});
      bus(1'b1, SA, rows[i].st, 4'h3, rd);
      repeat (2) @(posedge clk_sys);
      chk("irq cleared", 32'h0, {31'h0, host_irq});
      rdchk("status cleared", SA, 32'h4);
      bus(1'b1, EA, 16'h0000, 4'h3, rd);
    end
    $display("test source table done");
    bus(1'b1, EA, 16'h07fb, 4'h3, rd);
    rdchk("enable rw", EA, 32'h07fb);
    bus(1'b1, EA, 16'h0000, 4'h1, rd);
    rdchk("enable low lane only", EA, 32'h0700);
    bus(1'b1, 10'h000, 16'h00ff, 4'h3, rd);
    rdchk("unmapped read", 10'h000, 32'h0);
    rdchk("enable after unmapped write", EA, 32'h0700);
    bus(1'b1, EA, 16'h0000, 4'h3, rd);
    $display("test enable register done");
    pulse(10'h004);
    bus(1'b1, SA, 16'h0000, 4'h3, rd);
    bus(1'b1, SA, 16'h0004, 4'h3, rd);
    rdchk("zero write keeps flag", SA, 32'h000c);
    bus(1'b1, SA, 16'h0008, 4'h3, rd);
    $display("test write zero done");
    // Two flags set, only one enabled: the other must not hold the line up
    bus(1'b1, EA, 16'h0011, 4'h3, rd);
    pulse(10'h003);
    repeat (3) @(posedge clk_sys);
    chk("irq one enabled", 32'h1, {31'h0, host_irq});
    bus(1'b1, SA, 16'h0001, 4'h3, rd);
    repeat (2) @(posedge clk_sys);
    chk("irq other masked", 32'h0, {31'h0, host_irq});
    bus(1'b1, EA, 16'h0002, 4'h3, rd);
    repeat (2) @(posedge clk_sys);
    chk("irq late enable", 32'h1, {31'h0, host_irq});
    $display("test or of pairs done");
    // A frame start in the answer cycle of its own clearing write must survive
    fork
      bus(1'b1, SA, 16'h0002, 4'h3, rd);
      begin
        repeat (2) @(posedge clk_sys);
        evt <= 10'h002;
        @(posedge clk_sys);
        evt <= '0;
      end
    join
    rdchk("set beats clear", SA, 32'h0006);
    chk("irq kept", 32'h1, {31'h0, host_irq});
    $display("test set beats clear done");
    // Reset in mid-run with a flag and its enable standing
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("irq in reset", 32'h0, {31'h0, host_irq});
    chk("status in reset", 32'h0, {16'h0000, irq_status});
    sys_rst <= 1'b0;
    rdchk("enable after reset", EA, 32'h0);
    repeat (SETTLE) @(posedge clk_sys);
    chk("reserved bit again", 32'h4, {16'h0000, irq_status});
    $display("test mid-run reset done");
    complete_run();
  end

  // Watchdog: far beyond the few hundred cycles the tests need
  initial begin
    #(20 * 20000);
    err_count++;
    $display("ERROR watchdog expected finish seen timeout");
    complete_run();
  end
endmodule

// >>> uhi_host_irq.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
// What this block does
// [R1] Status bit 4 latches any change in the host operational registers.
// [R2] Status bit 3 latches DMA transfer completion; zero until one completes.
// [R3] Reserved status bit 2 reads 0 after reset, then 1 shortly after.
// [R4] Status bit 1 latches a start-of-frame event.
// [R5] Status bit 0 latches a microframe start-of-frame event.
// [R6] Interrupt asserts for a source only when its flag and enable are set.
// [R7] Enable register at index D6h, all bits read/write, reset to zero.
// [R8] Software writes reserved enable bits with their reset value.
// [R9] Enable bit 10 gates the dual-role event interrupt.
// [R10] Enable bit 9 gates isochronous descriptor completion interrupt.
// [R11] Enable bit 8 gates asynchronous-list descriptor completion interrupt.
// [R12] Enable bit 7 gates periodic-list descriptor completion interrupt.
// [R13] Enable bit 6 gates the clock-stable interrupt.
// [R14] Enable bit 5 gates the host suspend interrupt.
// [R15] Enable bit 4 gates operational-register change interrupt, any origin.
// [R16] Enable bit 3 gates the DMA completion interrupt.
// [R17] Enable bit 1 gates the start-of-frame interrupt.
// [R18] Enable bit 0 gates the microframe start-of-frame interrupt.
// [R19] Status bit 10 latches a dual-role event.
// [R20] Status bits 9, 8, 7 latch iso, async, periodic descriptor completions.
// [R21] Status bit 6 latches internal clocks becoming stable.
// [R22] Status bit 5 latches the host entering suspend.
// [R23] Interrupt is the OR of all flag-and-enable pairs, held while any stays.
// [R24] Writing 1 clears a status flag; writing 0 leaves it alone.
module uhi_host_irq #(
  parameter int SETTLE_CYC = uhi_pkg::SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [uhi_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [uhi_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [uhi_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire uhi_pkg::uhi_evt_s evt,
  output logic host_irq,
  output logic [uhi_pkg::REG_W-1:0] irq_status
);

  uhi_pkg::uhi_main_s st_ff;
  uhi_pkg::uhi_main_s nxt_st;

  logic req;
  logic wr_go;
  logic hit_stat;
  logic hit_en;
  logic [uhi_pkg::REG_W-1:0] lane_mask;
  logic [uhi_pkg::REG_W-1:0] set_vec;
  logic [uhi_pkg::REG_W-1:0] clr_vec;
  logic [uhi_pkg::REG_W-1:0] status;
  logic [uhi_pkg::REG_W-1:0] pending;
  logic settled;

  // Bus decode; every access waits exactly one cycle so read data can come from a flop
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~st_ff.ack;
  assign wr_go = avs_write & st_ff.ack;
  assign hit_stat = (avs_address == uhi_pkg::STATUS_ADDR);
  assign hit_en = (avs_address == uhi_pkg::ENABLE_ADDR);
  assign lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Map the event pulses onto their status positions
  always_comb begin
    set_vec = '0;
    set_vec[uhi_pkg::BIT_USOF] = evt.microframe_start; // see [R5]
    set_vec[uhi_pkg::BIT_SOF] = evt.frame_start; // see [R4]
    set_vec[uhi_pkg::BIT_DMA] = evt.dma_done; // see [R2]
    set_vec[uhi_pkg::BIT_OPR] = evt.op_reg_change; // see [R1]
    set_vec[uhi_pkg::BIT_SUSP] = evt.host_suspend; // see [R22]
    set_vec[uhi_pkg::BIT_CLK] = evt.clock_stable; // see [R21]
    set_vec[uhi_pkg::BIT_PER] = evt.periodic_done; // see [R20]
    set_vec[uhi_pkg::BIT_ASYNC] = evt.async_done; // see [R20]
    set_vec[uhi_pkg::BIT_ISO] = evt.iso_done; // see [R20]
    set_vec[uhi_pkg::BIT_DUAL] = evt.dual_role_event; // see [R19]
  end

  // Write-one-to-clear on the taken write cycle only
  assign clr_vec = (wr_go && hit_stat) ? (avs_writedata[uhi_pkg::REG_W-1:0] & lane_mask) : '0; // see [R24]

  // One sticky cell per implemented flag; bit 2 is the settle indicator, the rest read zero
  genvar gi;
  generate
    for (gi = 0; gi < uhi_pkg::REG_W; gi++) begin : g_flag
      if (uhi_pkg::FLAG_MASK[gi]) begin : g_cell
        uhi_sticky_flag u_flag (
          .clk_sys(clk_sys),
          .sys_rst(sys_rst),
          .set(set_vec[gi]),
          .clr(clr_vec[gi]),
          .flag(status[gi])
        );
      end else if (gi == uhi_pkg::BIT_RSVD) begin : g_rsvd
        assign status[gi] = settled; // see [R3]
      end else begin : g_zero
        assign status[gi] = 1'b0;
      end
    end
  endgenerate

  // Reserved bit comes up on its own after a fixed delay from reset
  uhi_settle_timer #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_settle (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .settled(settled)
  );

  // The reserved enable bit is stored but never gates anything, so a careless write is harmless
  assign pending = status & st_ff.enable & uhi_pkg::FLAG_MASK; // see [R6] [R9] [R10] [R11] [R12] [R13]

  // Register next state: handshake, read data, enable register, interrupt line
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = req & ~st_ff.ack;
    if (req && !st_ff.ack) begin
      if (avs_read && hit_stat) begin
        nxt_st.rdata = {16'h0000, status};
      end else if (avs_read && hit_en) begin
        nxt_st.rdata = {16'h0000, st_ff.enable}; // see [R7]
      end else begin
        nxt_st.rdata = uhi_pkg::RDATA_RESET;
      end
    end
    if (wr_go && hit_en) begin
      // All sixteen bits are plain storage, reserved ones included
      if (avs_byteenable[0]) begin
        nxt_st.enable[7:0] = avs_writedata[7:0]; // see [R7] [R8]
      end
      if (avs_byteenable[1]) begin
        nxt_st.enable[15:8] = avs_writedata[15:8]; // see [R7]
      end
    end
    // One-cycle latency keeps the line glitch-free from a flop
    nxt_st.irq = |pending; // see [R23] [R14] [R15] [R16] [R17] [R18]
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff.ack <= 1'b0;
      st_ff.irq <= 1'b0;
      st_ff.enable <= uhi_pkg::ENABLE_RESET;
      st_ff.rdata <= uhi_pkg::RDATA_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata = st_ff.rdata;
  assign host_irq = st_ff.irq;
  assign irq_status = status;

  // Checks on flags, enables and the interrupt line
  AST_IRQ_NEEDS_PAIR: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R6]
    host_irq |-> $past(|pending))
    else $error("interrupt without an enabled flag");

  AST_IRQ_HELD: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R23]
    (|pending) |=> host_irq)
    else $error("interrupt missing while an enabled flag is set");

  AST_ENABLE_RESET: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R7]
    $past(sys_rst) |-> (st_ff.enable == uhi_pkg::ENABLE_RESET))
    else $error("enable register not zero after reset");

  AST_RSVD_LOW_AFTER_RESET: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R3]
    $past(sys_rst) |-> !status[uhi_pkg::BIT_RSVD])
    else $error("reserved status bit high right after reset");

  AST_SOF_SETS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R4]
    evt.frame_start |=> status[uhi_pkg::BIT_SOF])
    else $error("frame start did not set its flag");

  AST_USOF_SETS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R5]
    evt.microframe_start |=> status[uhi_pkg::BIT_USOF])
    else $error("microframe start did not set its flag");

  AST_DMA_SETS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R2]
    evt.dma_done |=> status[uhi_pkg::BIT_DMA])
    else $error("dma completion did not set its flag");

  AST_OPR_SETS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R1]
    evt.op_reg_change |=> status[uhi_pkg::BIT_OPR])
    else $error("operational change did not set its flag");

  AST_SUSP_SETS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R22]
    evt.host_suspend |=> status[uhi_pkg::BIT_SUSP])
    else $error("suspend entry did not set its flag");

  AST_CLK_SETS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R21]
    evt.clock_stable |=> status[uhi_pkg::BIT_CLK])
    else $error("clock stable did not set its flag");

  AST_PER_SETS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R20]
    evt.periodic_done |=> status[uhi_pkg::BIT_PER])
    else $error("periodic completion did not set its flag");

  AST_ASYNC_SETS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R20]
    evt.async_done |=> status[uhi_pkg::BIT_ASYNC])
    else $error("async list completion did not set its flag");

  AST_ISO_SETS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R20]
    evt.iso_done |=> status[uhi_pkg::BIT_ISO])
    else $error("isochronous completion did not set its flag");

  AST_DUAL_SETS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R19]
    evt.dual_role_event |=> status[uhi_pkg::BIT_DUAL])
    else $error("dual-role event did not set its flag");

  // Each enabled flag must reach the line one cycle later, whatever the others do
  AST_DUAL_GATES: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R9]
    (status[uhi_pkg::BIT_DUAL] && st_ff.enable[uhi_pkg::BIT_DUAL]) |=> host_irq)
    else $error("enabled dual-role flag gave no interrupt");

  AST_ISO_GATES: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R10]
    (status[uhi_pkg::BIT_ISO] && st_ff.enable[uhi_pkg::BIT_ISO]) |=> host_irq)
    else $error("enabled isochronous flag gave no interrupt");

  AST_ASYNC_GATES: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R11]
    (status[uhi_pkg::BIT_ASYNC] && st_ff.enable[uhi_pkg::BIT_ASYNC]) |=> host_irq)
    else $error("enabled async list flag gave no interrupt");

  AST_PER_GATES: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R12]
    (status[uhi_pkg::BIT_PER] && st_ff.enable[uhi_pkg::BIT_PER]) |=> host_irq)
    else $error("enabled periodic flag gave no interrupt");

  AST_CLK_GATES: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R13]
    (status[uhi_pkg::BIT_CLK] && st_ff.enable[uhi_pkg::BIT_CLK]) |=> host_irq)
    else $error("enabled clock stable flag gave no interrupt");

  AST_SUSP_GATES: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R14]
    (status[uhi_pkg::BIT_SUSP] && st_ff.enable[uhi_pkg::BIT_SUSP]) |=> host_irq)
    else $error("enabled suspend flag gave no interrupt");

  AST_OPR_GATES: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R15]
    (status[uhi_pkg::BIT_OPR] && st_ff.enable[uhi_pkg::BIT_OPR]) |=> host_irq)
    else $error("enabled operational change flag gave no interrupt");

  AST_DMA_GATES: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R16]
    (status[uhi_pkg::BIT_DMA] && st_ff.enable[uhi_pkg::BIT_DMA]) |=> host_irq)
    else $error("enabled dma flag gave no interrupt");

  AST_SOF_GATES: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R17]
    (status[uhi_pkg::BIT_SOF] && st_ff.enable[uhi_pkg::BIT_SOF]) |=> host_irq)
    else $error("enabled frame start flag gave no interrupt");

  AST_USOF_GATES: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R18]
    (status[uhi_pkg::BIT_USOF] && st_ff.enable[uhi_pkg::BIT_USOF]) |=> host_irq)
    else $error("enabled microframe start flag gave no interrupt");

  AST_W1C_CLEARS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R24]
    (clr_vec[uhi_pkg::BIT_SOF] && !evt.frame_start) |=> !status[uhi_pkg::BIT_SOF])
    else $error("write of one did not clear the flag");

  AST_W0_KEEPS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R24]
    (status[uhi_pkg::BIT_DMA] && !clr_vec[uhi_pkg::BIT_DMA]) |=> status[uhi_pkg::BIT_DMA])
    else $error("flag lost without a clearing write");

  AST_SOF_MASKED: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R17]
    (status[uhi_pkg::BIT_SOF] && !st_ff.enable[uhi_pkg::BIT_SOF] &&
     (status & st_ff.enable & uhi_pkg::FLAG_MASK) == '0) |=> !host_irq)
    else $error("interrupt raised by a disabled source");

  AST_ONE_WAIT: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R7]
    (req && !st_ff.ack) |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
    else $error("bus answer not after one wait cycle");

  COV_IRQ_RISE: cover property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(host_irq));

  COV_CLEAR_WRITE: cover property (@(posedge clk_sys) disable iff (sys_rst)
    (|clr_vec) ##1 $fell(host_irq));

  COV_STATUS_READ: cover property (@(posedge clk_sys) disable iff (sys_rst)
    avs_read && hit_stat && st_ff.ack && (avs_readdata[15:0] != 16'h0000));

  COV_SET_AND_CLEAR: cover property (@(posedge clk_sys) disable iff (sys_rst)
    |(set_vec & clr_vec));

endmodule

// >>> uhi_pkg.sv
package uhi_pkg;

  // Bus and register geometry
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int ADDR_W = 10;

  // Printed offsets are register indices; byte address is four times that
  localparam logic [7:0] STATUS_IDX = 8'hd4;
  localparam logic [7:0] ENABLE_IDX = 8'hd6;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] ENABLE_ADDR = {ENABLE_IDX, 2'b00};

  // Field positions shared by status and enable
  localparam int BIT_USOF = 0;
  localparam int BIT_SOF = 1;
  localparam int BIT_RSVD = 2;
  localparam int BIT_DMA = 3;
  localparam int BIT_OPR = 4;
  localparam int BIT_SUSP = 5;
  localparam int BIT_CLK = 6;
  localparam int BIT_PER = 7;
  localparam int BIT_ASYNC = 8;
  localparam int BIT_ISO = 9;
  localparam int BIT_DUAL = 10;

  // Reset values and masks
  localparam logic [REG_W-1:0] ENABLE_RESET = 16'h0000;
  localparam logic [REG_W-1:0] FLAG_MASK = 16'h07fb;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

  // Settling delay of the reserved status bit
  localparam int CLK_NS = 20;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);

  // One-cycle event pulses from the host core
  typedef struct packed {
    logic dual_role_event;
    logic iso_done;
    logic async_done;
    logic periodic_done;
    logic clock_stable;
    logic host_suspend;
    logic op_reg_change;
    logic dma_done;
    logic frame_start;
    logic microframe_start;
  } uhi_evt_s;

  typedef enum logic [0:0] {
    SETTLE_WAIT = 1'b0,
    SETTLE_DONE = 1'b1
  } uhi_settle_e;

  typedef struct packed {
    uhi_settle_e phase;
    logic [SETTLE_W-1:0] cnt;
  } uhi_settle_s;

  typedef struct packed {
    logic flag;
  } uhi_flag_s;

  typedef struct packed {
    logic ack;
    logic irq;
    logic [REG_W-1:0] enable;
    logic [DATA_W-1:0] rdata;
  } uhi_main_s;

endpackage

// >>> uhi_settle_timer.sv
`timescale 1ns/1ps
module uhi_settle_timer #(
  parameter int SETTLE_CYC = uhi_pkg::SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  output logic settled
);

  uhi_pkg::uhi_settle_s st_ff;
  uhi_pkg::uhi_settle_s nxt_st;

  // Counts off the settle time once after reset, then holds
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.phase)
      uhi_pkg::SETTLE_WAIT: begin
        if (st_ff.cnt == uhi_pkg::SETTLE_W'(SETTLE_CYC - 1)) begin
          nxt_st.phase = uhi_pkg::SETTLE_DONE; // see [R3]
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      uhi_pkg::SETTLE_DONE: nxt_st.phase = uhi_pkg::SETTLE_DONE;
      default: nxt_st.phase = uhi_pkg::SETTLE_WAIT;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign settled = (st_ff.phase == uhi_pkg::SETTLE_DONE);

  // Helper: cycles since reset release, saturating
  logic [7:0] age_ff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      age_ff <= 8'h00;
    end else if (age_ff != 8'hff) begin
      age_ff <= age_ff + 8'h01;
    end
  end

  AST_RSVD_SETTLES: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R3]
    (age_ff >= 8'(SETTLE_CYC)) |-> settled)
    else $error("reserved bit did not settle in time");

  AST_RSVD_NOT_EARLY: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R3]
    (age_ff < 8'(SETTLE_CYC)) |-> !settled)
    else $error("reserved bit rose too early");

endmodule

// >>> uhi_sticky_flag.sv
`timescale 1ns/1ps
module uhi_sticky_flag (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic set,
  input wire logic clr,
  output logic flag
);

  uhi_pkg::uhi_flag_s st_ff;
  uhi_pkg::uhi_flag_s nxt_st;

  // Set beats clear so an event landing on a clearing write is kept
  always_comb begin
    nxt_st = st_ff;
    nxt_st.flag = set | (st_ff.flag & ~clr); // see [R24]
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign flag = st_ff.flag;

  AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (sys_rst) // see [R24]
    set |=> flag)
    else $error("flag lost an event");

endmodule
